// File: inc/hml_pkg.sv
// Package for the haptic mode and loop configuration bank: offsets, fields, reset values, codes
package hml_pkg;
    localparam logic [7:0] HML_TRIG_MODE_OFS = 8'h07;
    localparam logic [7:0] HML_ACT_LOOP_OFS = 8'h08;
    localparam logic [7:0] HML_TRIG_MODE_RST = 8'h44;
    localparam logic [7:0] HML_ACT_LOOP_RST = 8'h88;
    // trigger_and_mode_config fields
    localparam int HML_BCAST_BIT = 7;
    localparam int HML_AVG_OFF_BIT = 6;
    localparam int HML_COMP_LSB = 4;
    localparam int HML_PIN_FUNC_LSB = 2;
    localparam int HML_MODE_LSB = 0;
    // actuator_loop_config fields
    localparam int HML_ACT_TYPE_BIT = 7;
    localparam int HML_OPEN_LOOP_BIT = 6;
    localparam int HML_HYBRID_BIT = 5;
    localparam int HML_BRAKE_OL_BIT = 4;
    localparam int HML_BRAKE_STBY_BIT = 3;
    localparam int HML_SLOPE_BIT = 2;
    // Shared broadcast target address
    localparam logic [6:0] HML_BCAST_ADDR = 7'h58;
    // Drift compensation in percent per code
    localparam logic [6:0] HML_COMP_PCT0 = 7'h00;
    localparam logic [6:0] HML_COMP_PCT1 = 7'h02;
    localparam logic [6:0] HML_COMP_PCT2 = 7'h04;
    localparam logic [6:0] HML_COMP_PCT3 = 7'h05;
    localparam int HML_AVG_DEPTH = 4;
    localparam int HML_AVG_SHIFT = 2;
    localparam logic [3:0] HML_BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0] {
        HML_PIN_PULSE = 2'h0,
        HML_PIN_LEVEL = 2'h1,
        HML_PIN_IRQ = 2'h2,
        HML_PIN_RSVD = 2'h3
    } hml_pin_func_t;

    typedef enum logic [1:0] {
        HML_MODE_REALTIME = 2'h0,
        HML_MODE_SEQUENCER = 2'h1,
        HML_MODE_DIAG = 2'h2,
        HML_MODE_CALIB = 2'h3
    } hml_mode_t;

    typedef struct packed {
        hml_mode_t mode;
        logic resonant_actuator;
        logic open_loop;
        logic hybrid_loop;
        logic open_loop_brake;
        logic brake_before_standby;
        logic input_slope_check;
    } hml_cfg_t;
endpackage : hml_pkg

// File: rtl/hml_period_avg.sv
// Resonance period reporting with optional four-sample averaging
`timescale 1ns/100ps
module hml_period_avg
    import hml_pkg::*;
#(
    parameter int PW = 10
) (
    input wire logic ref_clk, // Core clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic period_valid, // New measured period this cycle
    input wire logic [PW-1:0] period_in, // Measured period
    input wire logic resonance_average_off, // 1: report last period only
    output logic [PW-1:0] resonance_period_report // Reported period
);
    logic [PW-1:0] history [HML_AVG_DEPTH];
    logic [PW+1:0] sum;

    // History starts all zeros, so early averages read low on purpose
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < HML_AVG_DEPTH; i++) begin
                history[i] <= '0;
            end
        end else if (period_valid) begin
            history[0] <= period_in;
            for (int i = 1; i < HML_AVG_DEPTH; i++) begin
                history[i] <= history[i-1];
            end
        end
    end

    always_comb begin
        sum = '0;
        for (int i = 0; i < HML_AVG_DEPTH; i++) begin
            sum = sum + {2'b00, history[i]};
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            resonance_period_report <= '0;
        end else if (resonance_average_off) begin
            resonance_period_report <= history[0];
        end else begin
            resonance_period_report <= sum[PW+1:HML_AVG_SHIFT];
        end
    end
endmodule : hml_period_avg

// File: rtl/hml_config.sv
// Trigger/mode and actuator/loop configuration registers with serial target and process control
`timescale 1ns/100ps
module hml_config
    import hml_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR = 7'h2A, // Arbitrary default target address
    parameter int PW = 10
) (
    input wire logic ref_clk, // Core clock, 250 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic scl_in, // Serial clock level
    input wire logic sda_in, // Serial data level
    output logic sda_oe, // High pulls serial data low
    input wire logic trigger_interrupt_pin_in, // Trigger pin level
    output logic trigger_interrupt_pin_oe, // High pulls trigger pin low
    input wire logic irq_request, // Interrupt condition from status logic
    input wire logic go_write, // Launch bit written this cycle
    input wire logic go_value, // Value written to launch bit
    input wire logic process_done, // Running process finished
    input wire logic standby_timer, // Idle timer asks for standby
    input wire logic actuator_moving, // Actuator still in motion
    input wire logic brake_done, // Braking has finished
    input wire logic period_valid, // Measured period strobe
    input wire logic [PW-1:0] period_in, // Measured resonance period
    input wire logic [7:0] drive_level_in, // Uncompensated drive level
    output logic [7:0] drive_level_out, // Compensated drive level
    output logic [PW-1:0] resonance_period_report, // Reported resonance period
    output hml_cfg_t cfg, // Decoded configuration
    output logic process_run, // Process executing
    output logic brake_active // Braking before standby
);
    typedef enum logic [2:0] {
        HML_I_IDLE = 3'b000,
        HML_I_ADDR = 3'b001,
        HML_I_ACK = 3'b011,
        HML_I_WRITE = 3'b010,
        HML_I_READ = 3'b110,
        HML_I_RACK = 3'b111
    } hml_i2c_st_t;

    typedef enum logic [1:0] {
        HML_P_STANDBY = 2'b00,
        HML_P_RUN = 2'b01,
        HML_P_BRAKE = 2'b11
    } hml_proc_st_t;

    logic [7:0] trigger_and_mode_config;
    logic [7:0] actuator_loop_config;
    hml_i2c_st_t i2c_st;
    hml_proc_st_t proc_st;
    logic scl_prev, sda_prev, pin_prev;
    logic [7:0] shift, ptr;
    logic [3:0] bit_cnt;
    logic rw, first, nack, ack_drive;
    logic wr_pulse;
    logic [7:0] wr_addr, wr_data, rd_data;
    logic start_cond, stop_cond, scl_rise, scl_fall, addr_hit;
    logic func_change, mode_change;
    logic start_req, cancel_req, stby_req;
    hml_pin_func_t pin_func;
    logic [6:0] pct;
    logic [14:0] comp_prod;
    logic [8:0] comp_sum;

    assign start_cond = scl_in && scl_prev && sda_prev && !sda_in;
    assign stop_cond = scl_in && scl_prev && !sda_prev && sda_in;
    assign scl_rise = scl_in && !scl_prev;
    assign scl_fall = !scl_in && scl_prev;
    assign addr_hit = (shift[7:1] == OWN_ADDR) ||
        (trigger_and_mode_config[HML_BCAST_BIT] && shift[7:1] == HML_BCAST_ADDR);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            pin_prev <= 1'b0;
        end else begin
            scl_prev <= scl_in;
            sda_prev <= sda_in;
            pin_prev <= trigger_interrupt_pin_in;
        end
    end

    always_comb begin
        case (ptr)
            HML_TRIG_MODE_OFS: rd_data = trigger_and_mode_config;
            HML_ACT_LOOP_OFS: rd_data = actuator_loop_config;
            default: rd_data = 8'h00;
        endcase
    end

    // Serial target: bytes after the address are a register pointer then data, pointer auto-increments
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            i2c_st <= HML_I_IDLE;
            shift <= 8'h00;
            ptr <= 8'h00;
            bit_cnt <= 4'h0;
            rw <= 1'b0;
            first <= 1'b0;
            nack <= 1'b0;
            ack_drive <= 1'b0;
            wr_pulse <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_pulse <= 1'b0;
            if (start_cond) begin
                i2c_st <= HML_I_ADDR;
                bit_cnt <= 4'h0;
                ack_drive <= 1'b0;
            end else if (stop_cond) begin
                i2c_st <= HML_I_IDLE;
                ack_drive <= 1'b0;
            end else begin
                case (i2c_st)
                    HML_I_ADDR, HML_I_WRITE: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_in};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == HML_BITS_PER_BYTE) begin
                            bit_cnt <= 4'h0;
                            if (i2c_st == HML_I_ADDR) begin
                                if (addr_hit) begin
                                    ack_drive <= 1'b1;
                                    rw <= shift[0];
                                    first <= 1'b1;
                                    i2c_st <= HML_I_ACK;
                                end else begin
                                    i2c_st <= HML_I_IDLE;
                                end
                            end else begin
                                ack_drive <= 1'b1;
                                i2c_st <= HML_I_ACK;
                                if (first) begin
                                    ptr <= shift;
                                    first <= 1'b0;
                                end else begin
                                    wr_pulse <= 1'b1;
                                    wr_addr <= ptr;
                                    wr_data <= shift;
                                    ptr <= ptr + 8'h01;
                                end
                            end
                        end
                    end
                    HML_I_ACK: begin
                        if (scl_fall) begin
                            ack_drive <= 1'b0;
                            bit_cnt <= 4'h0;
                            if (rw) begin
                                shift <= rd_data;
                                i2c_st <= HML_I_READ;
                            end else begin
                                i2c_st <= HML_I_WRITE;
                            end
                        end
                    end
                    HML_I_READ: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == HML_BITS_PER_BYTE) begin
                                ptr <= ptr + 8'h01;
                                i2c_st <= HML_I_RACK;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                            end
                        end
                    end
                    HML_I_RACK: begin
                        if (scl_rise) begin
                            nack <= sda_in;
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            shift <= rd_data;
                            i2c_st <= nack ? HML_I_IDLE : HML_I_READ;
                        end
                    end
                    default: i2c_st <= HML_I_IDLE;
                endcase
            end
        end
    end

    assign sda_oe = ack_drive || (i2c_st == HML_I_READ && !shift[7]);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            trigger_and_mode_config <= HML_TRIG_MODE_RST;
            actuator_loop_config <= HML_ACT_LOOP_RST;
        end else if (wr_pulse) begin
            if (wr_addr == HML_TRIG_MODE_OFS) begin
                trigger_and_mode_config <= wr_data;
            end
            if (wr_addr == HML_ACT_LOOP_OFS) begin
                actuator_loop_config <= wr_data;
            end
        end
    end

    assign pin_func = hml_pin_func_t'(trigger_and_mode_config[HML_PIN_FUNC_LSB +: 2]);
    assign func_change = wr_pulse && wr_addr == HML_TRIG_MODE_OFS &&
        wr_data[HML_PIN_FUNC_LSB +: 2] != trigger_and_mode_config[HML_PIN_FUNC_LSB +: 2];
    assign mode_change = wr_pulse && wr_addr == HML_TRIG_MODE_OFS &&
        wr_data[HML_MODE_LSB +: 2] != trigger_and_mode_config[HML_MODE_LSB +: 2];

    // Code 3 is reserved; pin and launch bit neither start nor stop anything, only the standby timer, process_done or a pin-function or mode change still ends a run
    always_comb begin
        start_req = 1'b0;
        cancel_req = 1'b0;
        stby_req = standby_timer;
        case (pin_func)
            HML_PIN_PULSE: begin
                start_req = (trigger_interrupt_pin_in && !pin_prev) || (go_write && go_value);
                cancel_req = go_write && !go_value;
            end
            HML_PIN_LEVEL: begin
                start_req = trigger_interrupt_pin_in;
                stby_req = standby_timer || !trigger_interrupt_pin_in;
            end
            HML_PIN_IRQ: begin
                start_req = go_write && go_value;
                cancel_req = go_write && !go_value;
            end
            default: begin
                start_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            proc_st <= HML_P_STANDBY;
        end else begin
            case (proc_st)
                HML_P_STANDBY: begin
                    if (start_req && !func_change && !mode_change) begin
                        proc_st <= HML_P_RUN;
                    end
                end
                HML_P_RUN: begin
                    if (func_change || mode_change || cancel_req || process_done) begin
                        proc_st <= HML_P_STANDBY;
                    end else if (stby_req) begin
                        proc_st <= (actuator_loop_config[HML_BRAKE_STBY_BIT] && actuator_moving) ?
                            HML_P_BRAKE : HML_P_STANDBY;
                    end
                end
                HML_P_BRAKE: begin
                    if (brake_done || !actuator_moving || func_change || mode_change) begin
                        proc_st <= HML_P_STANDBY;
                    end
                end
                default: proc_st <= HML_P_STANDBY;
            endcase
        end
    end

    assign process_run = proc_st == HML_P_RUN;
    assign brake_active = proc_st == HML_P_BRAKE;
    assign trigger_interrupt_pin_oe = pin_func == HML_PIN_IRQ && irq_request;

    assign cfg.mode = hml_mode_t'(trigger_and_mode_config[HML_MODE_LSB +: 2]);
    assign cfg.resonant_actuator = actuator_loop_config[HML_ACT_TYPE_BIT];
    assign cfg.open_loop = actuator_loop_config[HML_OPEN_LOOP_BIT];
    assign cfg.hybrid_loop = actuator_loop_config[HML_HYBRID_BIT];
    assign cfg.open_loop_brake = actuator_loop_config[HML_BRAKE_OL_BIT];
    assign cfg.brake_before_standby = actuator_loop_config[HML_BRAKE_STBY_BIT];
    assign cfg.input_slope_check = actuator_loop_config[HML_SLOPE_BIT];

    always_comb begin
        case (trigger_and_mode_config[HML_COMP_LSB +: 2])
            2'h0: pct = HML_COMP_PCT0;
            2'h1: pct = HML_COMP_PCT1;
            2'h2: pct = HML_COMP_PCT2;
            default: pct = HML_COMP_PCT3;
        endcase
    end

    assign comp_prod = drive_level_in * pct;
    assign comp_sum = {1'b0, drive_level_in} + 9'(comp_prod / 15'd100);

    // Saturates rather than wrapping so full drive never flips to near zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            drive_level_out <= 8'h00;
        end else begin
            drive_level_out <= comp_sum[8] ? 8'hFF : comp_sum[7:0];
        end
    end

    hml_period_avg #(.PW(PW)) u_period_avg (
        .ref_clk(ref_clk),
        .reset(reset),
        .period_valid(period_valid),
        .period_in(period_in),
        .resonance_average_off(trigger_and_mode_config[HML_AVG_OFF_BIT]),
        .resonance_period_report(resonance_period_report)
    );
endmodule : hml_config

// File: verification/hml_config_chk.sv
// Concurrent checks on the configuration bank ports
`timescale 1ns/100ps
module hml_config_chk
    import hml_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic reset, // Async reset, active high
    input wire logic scl_in, // Serial clock level
    input wire logic sda_oe, // Data pull-down
    input wire logic trigger_interrupt_pin_in, // Pin level
    input wire logic trigger_interrupt_pin_oe, // Pin pull-down
    input wire logic irq_request, // Interrupt condition
    input wire logic go_write, // Launch write strobe
    input wire logic go_value, // Launch value
    input wire logic actuator_moving, // Actuator in motion
    input wire logic brake_done, // Braking finished
    input wire logic [7:0] drive_level_in, // Raw drive
    input wire logic [7:0] drive_level_out, // Compensated drive
    input wire hml_cfg_t cfg, // Decoded configuration
    input wire logic process_run, // Process executing
    input wire logic brake_active // Braking
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    sequence s_cancel;
        process_run && go_write && !go_value && !trigger_interrupt_pin_in;
    endsequence
    sequence s_brake_end;
        brake_active && (brake_done || !actuator_moving);
    endsequence
    a_reset_cfg: assert property ($fell(reset) |-> cfg.mode == HML_MODE_REALTIME
        && cfg.resonant_actuator && !cfg.open_loop && !cfg.hybrid_loop && cfg.brake_before_standby)
        else $error("configuration differs from reset values");
    a_pin_oe_cause: assert property (trigger_interrupt_pin_oe |-> irq_request)
        else $error("pin pulled low without interrupt request");
    // The lower bound catches a lost gain, the upper bound a gain above the largest code
    a_drive_floor: assert property (!$past(reset) |-> drive_level_out >= $past(drive_level_in))
        else $error("drive level below raw input");
    a_drive_ceiling: assert property (!$past(reset) |->
        100 * drive_level_out <= 105 * $past(drive_level_in) || drive_level_out == 8'hFF)
        else $error("drive level above largest compensation");
    a_run_cause: assert property ($rose(process_run) |->
        $past(go_write && go_value) || $past(trigger_interrupt_pin_in))
        else $error("process started without launch or pin");
    a_cancel_stop: assert property (s_cancel |=> !process_run)
        else $error("cancel did not stop process");
    a_brake_cause: assert property ($rose(brake_active) |->
        $past(process_run && actuator_moving && cfg.brake_before_standby))
        else $error("braking without moving actuator or enable");
    a_brake_end: assert property (s_brake_end |=> !brake_active && !process_run)
        else $error("braking did not end in standby");
    a_run_brake_excl: assert property (!(process_run && brake_active))
        else $error("run and brake together");
    a_sda_low_phase: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pulled while clock high");
    a_sda_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data changed while clock high");
endmodule : hml_config_chk

bind hml_config hml_config_chk u_hml_chk (.ref_clk(ref_clk), .reset(reset), .scl_in(scl_in), .sda_oe(sda_oe),
    .trigger_interrupt_pin_in(trigger_interrupt_pin_in), .trigger_interrupt_pin_oe(trigger_interrupt_pin_oe),
    .irq_request(irq_request), .go_write(go_write), .go_value(go_value), .actuator_moving(actuator_moving),
    .brake_done(brake_done), .drive_level_in(drive_level_in), .drive_level_out(drive_level_out), .cfg(cfg),
    .process_run(process_run), .brake_active(brake_active));

// File: verification/hml_host_model.sv
// Serial bus controller model playing the host processor
`timescale 1ns/100ps
module hml_host_model (
    input wire logic ref_clk, // Pacing clock
    input wire logic sda, // Resolved data line
    output logic scl, // Serial clock
    output logic sda_low // High pulls data low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : hold
    // Data moves mid low phase, clear of both clock edges even behind a synchroniser
    task automatic send_bit(input logic b, output logic got);
        scl = 1'b0;
        hold(2);
        sda_low = !b;
        hold(3);
        scl = 1'b1;
        hold(2);
        got = sda;
        hold(1);
    endtask : send_bit
    task automatic bus_start();
        logic unused;
        send_bit(1'b1, unused);
        sda_low = 1'b1;
        hold(3);
    endtask : bus_start
    task automatic bus_stop();
        logic unused;
        send_bit(1'b0, unused);
        sda_low = 1'b0;
        hold(3);
    endtask : bus_stop
    task automatic send_byte(input logic [7:0] d, input logic last, output logic [7:0] q, output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--) send_bit(d[i], q[i]);
        send_bit(last, a);
        acked = !a;
    endtask : send_byte
endmodule : hml_host_model

// File: verification/tb_top.sv
// Self-checking bench for the mode and loop configuration bank
`timescale 1ns/100ps
module tb_top;
    import hml_pkg::*;
    typedef struct {logic [1:0] code; logic [7:0] din; logic [7:0] dout;} hml_row_t;
    localparam logic [6:0] DEV = 7'h2A; // Arbitrary target address
    hml_row_t rows [6] = '{'{2'h0, 8'hC8, 8'hC8}, '{2'h1, 8'hC8, 8'hCC}, '{2'h2, 8'hC8, 8'hD0},
        '{2'h3, 8'hC8, 8'hD2}, '{2'h1, 8'h64, 8'h66}, '{2'h3, 8'hFA, 8'hFF}};
    logic ref_clk, reset, scl, host_low, pin_drv, irq_request, go_write, go_value, process_done;
    logic standby_timer, actuator_moving, brake_done, period_valid, sda_oe, pin_oe, process_run, brake_active, ack;
    logic [9:0] period_in, report;
    logic [7:0] drive_in, drive_out, rd;
    hml_cfg_t cfg;
    int fail_count, samples_checked;
    wire logic sda = !(host_low || sda_oe);
    wire logic pin = pin_drv && !pin_oe;
    hml_config #(.OWN_ADDR(DEV)) uut (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_oe(sda_oe),
        .trigger_interrupt_pin_in(pin), .trigger_interrupt_pin_oe(pin_oe), .irq_request(irq_request),
        .go_write(go_write), .go_value(go_value), .process_done(process_done), .standby_timer(standby_timer),
        .actuator_moving(actuator_moving), .brake_done(brake_done), .period_valid(period_valid),
        .period_in(period_in), .drive_level_in(drive_in), .drive_level_out(drive_out),
        .resonance_period_report(report), .cfg(cfg), .process_run(process_run), .brake_active(brake_active));
    hml_host_model u_host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(host_low));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = !ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    task automatic reg_xfer(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] wd, input logic rnw);
        logic [7:0] tmp;
        logic a;
        u_host.bus_start();
        u_host.send_byte({dev, 1'b0}, 1'b1, tmp, ack);
        u_host.send_byte(ofs, 1'b1, tmp, a);
        if (rnw) begin
            u_host.bus_start();
            u_host.send_byte({dev, 1'b1}, 1'b1, tmp, a);
            u_host.send_byte(8'hFF, 1'b1, rd, a);
        end else begin
            u_host.send_byte(wd, 1'b1, tmp, a);
        end
        u_host.bus_stop();
    endtask : reg_xfer
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        reg_xfer(DEV, ofs, d, 1'b0);
    endtask : wr
    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        reg_xfer(DEV, ofs, 8'h00, 1'b1);
        chk("register", {2'b00, exp}, {2'b00, rd});
    endtask : rd_chk
    task automatic send_period(input logic [9:0] v);
        period_in = v;
        period_valid = 1'b1;
        tick(1);
        period_valid = 1'b0;
        tick(2);
    endtask : send_period
    task automatic go(input logic v);
        tick(1);
        go_write = 1'b1;
        go_value = v;
        tick(1);
        go_write = 1'b0;
    endtask : go
    initial begin
        #80000;
        fail_count++;
        give_verdict();
    end
    initial begin
        reset = 1'b1;
        {pin_drv, irq_request, go_write, go_value, process_done} = '0;
        {standby_timer, actuator_moving, brake_done, period_valid} = '0;
        period_in = '0;
        drive_in = '0;
        fail_count = 0;
        samples_checked = 0;
        tick(10);
        reset = 1'b0;
        tick(1);
        rd_chk(HML_TRIG_MODE_OFS, 8'h44);
        rd_chk(HML_ACT_LOOP_OFS, 8'h88);
        rd_chk(8'h10, 8'h00);
        send_period(10'h064);
        chk("period", 10'h064, report);
        foreach (rows[i]) begin
            wr(HML_TRIG_MODE_OFS, {2'b01, rows[i].code, 4'h4});
            drive_in = rows[i].din;
            tick(2);
            chk("drive", {2'b00, rows[i].dout}, {2'b00, drive_out});
        end
        for (int m = 0; m < 4; m++) begin
            wr(HML_TRIG_MODE_OFS, 8'h44 | 8'(m));
            chk("mode", 10'(m), 10'(cfg.mode));
        end
        reg_xfer(HML_BCAST_ADDR, HML_TRIG_MODE_OFS, 8'h00, 1'b1);
        chk("shared ack off", 10'h000, 10'(ack));
        wr(HML_TRIG_MODE_OFS, 8'hC4);
        reg_xfer(HML_BCAST_ADDR, HML_TRIG_MODE_OFS, 8'h00, 1'b1);
        chk("shared ack on", 10'h001, 10'(ack));
        chk("shared read", 10'h0C4, {2'b00, rd});
        // History already holds the earlier sample, so the first mean is (200 + 100) / 4
        wr(HML_TRIG_MODE_OFS, 8'h04);
        send_period(10'h0C8);
        chk("period", 10'h04B, report);
        send_period(10'h024);
        send_period(10'h028);
        send_period(10'h004);
        chk("period", 10'h046, report);
        wr(HML_TRIG_MODE_OFS, 8'h40);
        pin_drv = 1'b1;
        tick(1);
        chk("run", 10'h001, 10'(process_run));
        pin_drv = 1'b0;
        go(1'b0);
        chk("run", 10'h000, 10'(process_run));
        go(1'b1);
        chk("run", 10'h001, 10'(process_run));
        wr(HML_TRIG_MODE_OFS, 8'h48);
        chk("run", 10'h000, 10'(process_run));
        pin_drv = 1'b1;
        tick(1);
        chk("run", 10'h000, 10'(process_run));
        irq_request = 1'b1;
        tick(1);
        chk("pin_oe", 10'h001, 10'(pin_oe));
        irq_request = 1'b0;
        go(1'b1);
        chk("run", 10'h001, 10'(process_run));
        wr(HML_TRIG_MODE_OFS, 8'h49);
        chk("run", 10'h000, 10'(process_run));
        pin_drv = 1'b0;
        wr(HML_TRIG_MODE_OFS, 8'h44);
        go(1'b1);
        chk("run", 10'h000, 10'(process_run));
        pin_drv = 1'b1;
        tick(1);
        chk("run", 10'h001, 10'(process_run));
        go(1'b0);
        chk("run", 10'h001, 10'(process_run));
        actuator_moving = 1'b1;
        pin_drv = 1'b0;
        tick(1);
        chk("brake", 10'h001, 10'(brake_active));
        brake_done = 1'b1;
        tick(1);
        brake_done = 1'b0;
        chk("brake", 10'h000, 10'(brake_active));
        // A finished process skips braking; a timer request still brakes the moving actuator
        pin_drv = 1'b1;
        tick(1);
        chk("run", 10'h001, 10'(process_run));
        process_done = 1'b1;
        tick(1);
        process_done = 1'b0;
        chk("run", 10'h000, 10'(process_run));
        chk("brake", 10'h000, 10'(brake_active));
        standby_timer = 1'b1;
        tick(2);
        standby_timer = 1'b0;
        chk("brake", 10'h001, 10'(brake_active));
        pin_drv = 1'b0;
        actuator_moving = 1'b0;
        tick(1);
        actuator_moving = 1'b1;
        chk("brake", 10'h000, 10'(brake_active));
        wr(HML_ACT_LOOP_OFS, 8'h80);
        chk("loop", 10'h020, 10'(cfg[5:0]));
        pin_drv = 1'b1;
        tick(1);
        pin_drv = 1'b0;
        tick(1);
        chk("brake", 10'h000, 10'(brake_active));
        chk("run", 10'h000, 10'(process_run));
        wr(HML_ACT_LOOP_OFS, 8'h60);
        chk("loop", 10'h018, 10'(cfg[5:0]));
        give_verdict();
    end
endmodule : tb_top
